//--- src/qpio_top.sv
// Four 8-bit parallel ports with latches, pin reads and alternate functions.
module qpio_top (
    input  wire logic        MCLK,
    input  wire logic        NRST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // External memory access from the core.
    input  wire logic        EXT_START,
    input  wire logic        EXT_ACTIVE,
    input  wire logic [7:0]  EXT_ADDR_LOW_DATA,
    input  wire logic [15:0] EXT_ADDR_HIGH,
    input  wire logic        EXT_WR_STROBE,
    input  wire logic        EXT_RD_STROBE,
    // Peripheral outputs routed to pins.
    input  wire logic        PULSE_OUT_A,
    input  wire logic        PULSE_OUT_B,
    input  wire logic        SPI_CLOCK_OUT,
    input  wire logic        SPI_MOSI_OUT,
    input  wire logic        SPI_MISO_OUT,
    input  wire logic        UART_TX,
    input  wire logic        UART_RX_OUT,
    // Peripheral inputs taken from pins (synchronised), plus the port one analog select.
    output logic             PULSE_GEN_ALT_CLOCK,
    output logic             TIMER_C_CLOCK_INPUT,
    output logic             TIMER_C_EXT_CONTROL,
    output logic             SPI_SLAVE_SEL,
    output logic             SPI_MISO_IN,
    output logic             UART_RX,
    output logic             EXT_IRQ_A,
    output logic             EXT_IRQ_B,
    output logic             TIMER_A_COUNT_INPUT,
    output logic             TIMER_B_COUNT_INPUT,
    output logic [7:0]       ANALOG_SEL,
    // Pins, three signals each for ports zero, two and three; port one has an input only.
    input  wire logic [7:0]  PZ_IN,
    output logic      [7:0]  PZ_OUT,
    output logic      [7:0]  PZ_OE,
    input  wire logic [7:0]  PO_IN,
    input  wire logic [7:0]  PT_IN,
    output logic      [7:0]  PT_OUT,
    output logic      [7:0]  PT_OE,
    input  wire logic [7:0]  PH_IN,
    output logic      [7:0]  PH_OUT,
    output logic      [7:0]  PH_OE
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] zero_q, one_q, two_q, three_q;
    logic [7:0] alt_q;
    logic [7:0] pz_s, po_s, pt_s, ph_s;
    logic       wr_en, rd_en;
    logic [7:0] wdat;
    logic [31:0] rdata_d;
    logic       err_d;
    logic [1:0] op_port;
    logic [2:0] op_bit;
    logic [1:0] op_code;
    logic       op_val;
    logic [7:0] op_new;
    logic       bit_op_wr;
    logic [7:0] pz_out_d, pz_oe_d, pt_out_d, pt_oe_d, ph_out_d, ph_oe_d;

    // Returns the latch byte of a port number.
    function automatic logic [7:0] latch_of(input logic [1:0] p,
        input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] c, input logic [7:0] d);
        case (p)
            2'h0: latch_of = a;
            2'h1: latch_of = b;
            2'h2: latch_of = c;
            default: latch_of = d;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    qpio_sync #(.W(8)) u_sz (.clk(MCLK), .rst_n(NRST), .din(PZ_IN),
                             .dout(pz_s));
    qpio_sync #(.W(8)) u_so (.clk(MCLK), .rst_n(NRST), .din(PO_IN),
                             .dout(po_s));
    qpio_sync #(.W(8)) u_st (.clk(MCLK), .rst_n(NRST), .din(PT_IN),
                             .dout(pt_s));
    qpio_sync #(.W(8)) u_sh (.clk(MCLK), .rst_n(NRST), .din(PH_IN),
                             .dout(ph_s));

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Writes land in the access phase; reads are captured at setup.
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;
    assign wdat  = PWDATA[7:0];

    // The bit operation fields come straight from the write data.
    assign op_bit  = PWDATA[qpio_pkg::BIT_OP_SEL_LSB +: 3];
    assign op_port = PWDATA[qpio_pkg::BIT_OP_PORT_LSB +: 2];
    assign op_code = PWDATA[qpio_pkg::BIT_OP_CODE_LSB +: 2];
    assign op_val  = PWDATA[qpio_pkg::BIT_OP_VAL];
    assign bit_op_wr = wr_en && (PADDR == qpio_pkg::OFS_BIT_OP);

    // Whole latch byte is read, one bit changed, full byte written back.
    always_comb begin
        op_new = latch_of(op_port, zero_q, one_q, two_q, three_q);
        unique case (op_code)
            qpio_pkg::OP_MOVE: op_new[op_bit] = op_val;
            qpio_pkg::OP_CLR:  op_new[op_bit] = 1'b0;
            qpio_pkg::OP_SET:  op_new[op_bit] = 1'b1;
            qpio_pkg::OP_CPL:  op_new[op_bit] = ~op_new[op_bit];
        endcase
    end

    // ------------------------------------------------------------------
    // Port latches
    // ------------------------------------------------------------------
    // Port zero also takes all ones at the start of an external access,
    // which wins over a software write in the same cycle.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            zero_q <= qpio_pkg::LATCH_RESET;
        end else if (EXT_START) begin
            zero_q <= qpio_pkg::LATCH_RESET;
        end else if (wr_en && PADDR == qpio_pkg::OFS_PORT_ZERO) begin
            zero_q <= wdat;
        end else if (bit_op_wr && op_port == 2'h0) begin
            zero_q <= op_new;
        end
    end

    // Port one latch only selects analog or digital input.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            one_q <= qpio_pkg::LATCH_RESET;
        end else if (wr_en && PADDR == qpio_pkg::OFS_PORT_ONE) begin
            one_q <= wdat;
        end else if (bit_op_wr && op_port == 2'h1) begin
            one_q <= op_new;
        end
    end

    // Port two latch.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            two_q <= qpio_pkg::LATCH_RESET;
        end else if (wr_en && PADDR == qpio_pkg::OFS_PORT_TWO) begin
            two_q <= wdat;
        end else if (bit_op_wr && op_port == 2'h2) begin
            two_q <= op_new;
        end
    end

    // Port three latch.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            three_q <= qpio_pkg::LATCH_RESET;
        end else if (wr_en && PADDR == qpio_pkg::OFS_PORT_THREE) begin
            three_q <= wdat;
        end else if (bit_op_wr && op_port == 2'h3) begin
            three_q <= op_new;
        end
    end

    // Alternate function enables; all off so port two and the port three strobe pins start as plain ports.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            alt_q <= qpio_pkg::ALT_RESET;
        end else if (wr_en && PADDR == qpio_pkg::OFS_ALT_CTRL) begin
            alt_q <= wdat;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Latch offsets return latches, pin offsets return sampled levels.
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        unique case (PADDR)
            qpio_pkg::OFS_PORT_ZERO:  rdata_d[7:0] = zero_q;
            qpio_pkg::OFS_PORT_ONE:   rdata_d[7:0] = one_q;
            qpio_pkg::OFS_PORT_TWO:   rdata_d[7:0] = two_q;
            qpio_pkg::OFS_PORT_THREE: rdata_d[7:0] = three_q;
            qpio_pkg::OFS_PIN_ZERO:   rdata_d[7:0] = pz_s;
            qpio_pkg::OFS_PIN_ONE:    rdata_d[7:0] = po_s;
            qpio_pkg::OFS_PIN_TWO:    rdata_d[7:0] = pt_s;
            qpio_pkg::OFS_PIN_THREE:  rdata_d[7:0] = ph_s;
            qpio_pkg::OFS_ALT_CTRL:   rdata_d[7:0] = alt_q;
            qpio_pkg::OFS_BIT_OP:     rdata_d      = 32'h0000_0000;
            default:                  err_d        = 1'b1;
        endcase
    end

    // Read data is captured in the setup cycle so it is valid in access.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (rd_en) begin
            PRDATA  <= rdata_d;
            PSLVERR <= err_d;
        end else if (PSEL && !PENABLE) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= err_d;
        end
    end

    // The slave never waits, so ready is held high once out of reset.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    always_comb begin
        // Port zero: push-pull bus during external access, else open drain.
        if (EXT_ACTIVE) begin
            pz_out_d = EXT_ADDR_LOW_DATA;
            pz_oe_d  = 8'hff;
        end else begin
            pz_out_d = 8'h00;
            pz_oe_d  = ~zero_q;
        end
        // Port two: drive low for zero, else weak pull-up acts as input.
        pt_out_d = 8'h00;
        pt_oe_d  = ~two_q;
        if (EXT_ACTIVE) begin
            pt_out_d = EXT_ADDR_HIGH[7:0];
            pt_oe_d  = 8'hff;
        end
        if (alt_q[qpio_pkg::ALT_SPI]) begin
            pt_out_d[1:0] = {SPI_MOSI_OUT, SPI_CLOCK_OUT};
            pt_oe_d[1:0]  = 2'b11;
            pt_out_d[2]   = SPI_MISO_OUT;
            pt_oe_d[2]    = 1'b1;
            pt_oe_d[3]    = 1'b0;
        end
        if (alt_q[qpio_pkg::ALT_TIMER_C]) begin
            pt_oe_d[4:3] = 2'b00;
        end
        if (alt_q[qpio_pkg::ALT_PULSE_A]) begin
            pt_out_d[5] = PULSE_OUT_A;
            pt_oe_d[5]  = 1'b1;
        end
        if (alt_q[qpio_pkg::ALT_PULSE_B]) begin
            pt_out_d[6] = PULSE_OUT_B;
            pt_oe_d[6]  = 1'b1;
        end
        if (alt_q[qpio_pkg::ALT_PCLK]) begin
            pt_oe_d[7] = 1'b0;
        end
        // Port three: an alternate output shows only while its latch is 1;
        // the pin falls back to the latch level, so a 0 latch holds it low.
        ph_out_d = 8'h00;
        ph_oe_d  = ~three_q;
        if (three_q[1]) begin
            ph_out_d[1] = UART_TX;
            ph_oe_d[1]  = ~UART_TX;
        end
        if (three_q[0]) begin
            ph_oe_d[0] = ~UART_RX_OUT;
        end
        if (alt_q[qpio_pkg::ALT_EXT_MEM]) begin
            ph_oe_d[6] = three_q[6] ? ~EXT_WR_STROBE : 1'b1;
            ph_oe_d[7] = three_q[7] ? ~EXT_RD_STROBE : 1'b1;
        end
    end

    // All pin outputs are registered.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            PZ_OUT <= 8'h00;
            PZ_OE  <= 8'h00;
            PT_OUT <= 8'h00;
            PT_OE  <= 8'h00;
            PH_OUT <= 8'h00;
            PH_OE  <= 8'h00;
        end else begin
            PZ_OUT <= pz_out_d;
            PZ_OE  <= pz_oe_d;
            PT_OUT <= pt_out_d;
            PT_OE  <= pt_oe_d;
            PH_OUT <= ph_out_d;
            PH_OE  <= ph_oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Inputs to peripherals
    // ------------------------------------------------------------------
    // Port one never drives; its latch only reports analog selection.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ANALOG_SEL          <= qpio_pkg::LATCH_RESET;
            PULSE_GEN_ALT_CLOCK <= 1'b0;
            TIMER_C_CLOCK_INPUT <= 1'b0;
            TIMER_C_EXT_CONTROL <= 1'b0;
            SPI_SLAVE_SEL       <= 1'b1;
            SPI_MISO_IN         <= 1'b0;
            UART_RX             <= 1'b1;
            EXT_IRQ_A           <= 1'b1;
            EXT_IRQ_B           <= 1'b1;
            TIMER_A_COUNT_INPUT <= 1'b0;
            TIMER_B_COUNT_INPUT <= 1'b0;
        end else begin
            ANALOG_SEL          <= one_q;
            PULSE_GEN_ALT_CLOCK <= pt_s[7];
            SPI_SLAVE_SEL       <= pt_s[3];
            TIMER_C_CLOCK_INPUT <= pt_s[3];
            TIMER_C_EXT_CONTROL <= pt_s[4];
            SPI_MISO_IN         <= pt_s[2];
            UART_RX             <= ph_s[0];
            EXT_IRQ_A           <= ph_s[2];
            EXT_IRQ_B           <= ph_s[3];
            TIMER_A_COUNT_INPUT <= ph_s[4];
            TIMER_B_COUNT_INPUT <= ph_s[5];
        end
    end
endmodule

//--- src/qpio_pkg.sv
// Package of register map, reset values and field positions for the ports.
package qpio_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_ZERO  = 8'h80;
    localparam logic [7:0] OFS_PORT_ONE   = 8'h90;
    localparam logic [7:0] OFS_PORT_TWO   = 8'ha0;
    localparam logic [7:0] OFS_PORT_THREE = 8'hb0;
    localparam logic [7:0] OFS_PIN_ZERO   = 8'h84;
    localparam logic [7:0] OFS_PIN_ONE    = 8'h94;
    localparam logic [7:0] OFS_PIN_TWO    = 8'ha4;
    localparam logic [7:0] OFS_PIN_THREE  = 8'hb4;
    localparam logic [7:0] OFS_BIT_OP     = 8'hc0;
    localparam logic [7:0] OFS_ALT_CTRL   = 8'hc4;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LATCH_RESET    = 8'hff;
    localparam logic [7:0] ALT_RESET      = 8'h00;
    // ------------------------------------------------------------------
    // Bit-operation register fields
    // ------------------------------------------------------------------
    localparam int BIT_OP_SEL_LSB  = 0;   // Bit number, 3 bits.
    localparam int BIT_OP_PORT_LSB = 4;   // Port number, 2 bits.
    localparam int BIT_OP_CODE_LSB = 8;   // Operation, 2 bits.
    localparam int BIT_OP_VAL      = 12;  // Value for move.
    localparam logic [1:0] OP_MOVE = 2'h0;
    localparam logic [1:0] OP_CLR  = 2'h1;
    localparam logic [1:0] OP_SET  = 2'h2;
    localparam logic [1:0] OP_CPL  = 2'h3;
    // ------------------------------------------------------------------
    // Alternate control fields
    // ------------------------------------------------------------------
    localparam int ALT_PULSE_A = 0;
    localparam int ALT_PULSE_B = 1;
    localparam int ALT_SPI     = 2;
    localparam int ALT_TIMER_C = 3;
    localparam int ALT_PCLK    = 4;
    localparam int ALT_EXT_MEM = 5;
endpackage

//--- src/qpio_sync.sv
// Two-stage synchroniser for a bus of pin levels.
module qpio_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage. Both stages reset to the
    // released, pulled-up pin level, so leaving reset shows no false falling
    // edge to the interrupt, serial or counter inputs behind the pins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '1;
            dout   <= '1;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

//--- sim/qpio_checker.sv
// Checker of bus answers and pin timing for the parallel ports.
module qpio_checker (
    input wire logic        MCLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        EXT_START,
    input wire logic        EXT_ACTIVE,
    input wire logic [7:0]  EXT_ADDR_LOW_DATA,
    input wire logic [15:0] EXT_ADDR_HIGH,
    input wire logic [7:0]  PZ_OUT,
    input wire logic [7:0]  PZ_OE,
    input wire logic [7:0]  PT_OUT,
    input wire logic [7:0]  PT_OE,
    input wire logic [7:0]  PH_IN,
    input wire logic        EXT_IRQ_A,
    input wire logic        EXT_IRQ_B
);
    logic [1:0] up_q;
    logic       map_ok;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Pin history is only meaningful three edges after reset.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    // Latch and pin words of the four ports, bit operation, alt control.
    assign map_ok = PADDR[1:0] == 2'h0 && !PADDR[3] &&
                    (PADDR[7:6] == 2'h2 || PADDR[7:2] == 6'h30 ||
                     PADDR[7:2] == 6'h31);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ready_in_access: assert property (PSEL && PENABLE |-> PREADY)
        else $error("Ready low in access phase");
    a_err_on_unmapped: assert property (
        PSEL && !PENABLE |=> PSLVERR == !map_ok)
        else $error("Error flag does not match the address map");
    a_read_upper_zero: assert property (
        PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("Upper read data not zero");
    a_ext_low_bus: assert property (
        EXT_ACTIVE |=> PZ_OE == 8'hff && PZ_OUT == $past(EXT_ADDR_LOW_DATA))
        else $error("Low bus not driven during external access");
    a_ext_high_addr: assert property (
        EXT_ACTIVE |=> PT_OE == 8'hff && PT_OUT == $past(EXT_ADDR_HIGH[7:0]))
        else $error("High address not driven during external access");
    a_open_drain_low: assert property (
        !EXT_ACTIVE && !$past(EXT_ACTIVE) |-> (PZ_OUT & PZ_OE) == 8'h00)
        else $error("Port zero drove a pin high");
    a_start_floats: assert property (
        EXT_START ##1 (!EXT_ACTIVE && !(PSEL && PWRITE))[*3]
        |-> PZ_OE == 8'h00)
        else $error("Port zero still drives after access start");
    a_pin_sync_delay: assert property (
        up_q == 2'h3 |-> {EXT_IRQ_B, EXT_IRQ_A} == $past(PH_IN[3:2], 3))
        else $error("Interrupt inputs not three cycles behind pins");
    c_ext_access: cover property (EXT_ACTIVE);
    c_unmapped: cover property (PSEL && PENABLE && !map_ok);
    c_access_start: cover property (EXT_START);
endmodule

bind qpio_top qpio_checker i_qpio_checker (
    .MCLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
    .PSLVERR, .EXT_START, .EXT_ACTIVE, .EXT_ADDR_LOW_DATA, .EXT_ADDR_HIGH,
    .PZ_OUT, .PZ_OE, .PT_OUT, .PT_OE, .PH_IN, .EXT_IRQ_A, .EXT_IRQ_B
);

//--- sim/qpio_pins.sv
// Model of the board around the ports: pull-ups and outside parts.
module qpio_pins (
    input  wire logic [7:0] pz_out,
    input  wire logic [7:0] pz_oe,
    input  wire logic [7:0] pt_out,
    input  wire logic [7:0] pt_oe,
    input  wire logic [7:0] ph_out,
    input  wire logic [7:0] ph_oe,
    input  wire logic [7:0] sink,
    input  wire logic [7:0] src,
    output logic      [7:0] pz_in,
    output logic      [7:0] pt_in,
    output logic      [7:0] ph_in
);
    // Released pins rise through a pull-up; an outside part may sink one.
    // The same sink mask goes to all three ports to keep the model small.
    assign pz_in = ((pz_oe & pz_out) | ~pz_oe) & ~sink;
    assign pt_in = ((pt_oe & pt_out) | ~pt_oe) & ~sink & src;
    assign ph_in = ((ph_oe & ph_out) | ~ph_oe) & ~sink;
endmodule

//--- sim/qpio_top_tb.sv
// Self-checking bench for the four parallel ports.
module qpio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
    logic        MCLK, NRST, PSEL, PENABLE, PWRITE, EXT_START, EXT_ACTIVE;
    logic        EXT_WR_STROBE, EXT_RD_STROBE, PULSE_OUT_A, PULSE_OUT_B;
    logic        SPI_CLOCK_OUT, SPI_MOSI_OUT, UART_TX, PREADY, PSLVERR, serr;
    logic        PULSE_GEN_ALT_CLOCK, TIMER_C_CLOCK_INPUT, TIMER_C_EXT_CONTROL;
    logic        SPI_SLAVE_SEL, EXT_IRQ_A, EXT_IRQ_B, SPI_MISO_IN, UART_RX;
    logic        TIMER_A_COUNT_INPUT, TIMER_B_COUNT_INPUT;
    logic [7:0]  PADDR, EXT_ADDR_LOW_DATA, sink, PO_IN, ANALOG_SEL;
    logic [7:0]  PZ_IN, PZ_OUT, PZ_OE, PT_IN, PT_OUT, PT_OE, PH_IN, PH_OUT;
    logic [7:0]  PH_OE;
    logic [15:0] EXT_ADDR_HIGH;
    logic [31:0] PWDATA, PRDATA, rdat;
    int          error_cnt, compares, cyc;

    qpio_top i_qpio_top (.MCLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EXT_START, .EXT_ACTIVE,
        .EXT_ADDR_LOW_DATA, .EXT_ADDR_HIGH, .EXT_WR_STROBE, .EXT_RD_STROBE,
        .PULSE_OUT_A, .PULSE_OUT_B, .SPI_CLOCK_OUT, .SPI_MOSI_OUT,
        .SPI_MISO_OUT(1'b0), .UART_TX, .UART_RX_OUT(1'b0),
        .PULSE_GEN_ALT_CLOCK, .TIMER_C_CLOCK_INPUT, .TIMER_C_EXT_CONTROL,
        .SPI_SLAVE_SEL, .SPI_MISO_IN, .UART_RX, .EXT_IRQ_A, .EXT_IRQ_B,
        .TIMER_A_COUNT_INPUT, .TIMER_B_COUNT_INPUT, .ANALOG_SEL, .PZ_IN,
        .PZ_OUT, .PZ_OE, .PO_IN, .PT_IN, .PT_OUT, .PT_OE, .PH_IN, .PH_OUT,
        .PH_OE);
    qpio_pins i_qpio_pins (.pz_out(PZ_OUT), .pz_oe(PZ_OE), .pt_out(PT_OUT),
        .pt_oe(PT_OE), .ph_out(PH_OUT), .ph_oe(PH_OE), .sink, .src(8'hff),
        .pz_in(PZ_IN), .pt_in(PT_IN), .ph_in(PH_IN));

    // Free-running core clock of 25 ns.
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    // A hang is cut short well beyond the length of the whole run.
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One transfer: setup, then access held until ready is seen.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        serr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read data", {24'h0, e}, rdat)
        `CHK("error flag", 1'b0, serr)
    endtask
    // Output register plus the three-stage pin path.
    task automatic settle();
        repeat (5) @(posedge MCLK);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk(8'h80, 8'hff);
        rchk(8'ha0, 8'hff);
        rchk(8'hb0, 8'hff);
        rchk(8'h90, 8'hff);
        `CHK("analog select", 8'hff, ANALOG_SEL)
        `CHK("port zero pins", 8'hff, PZ_IN)
    endtask
    task automatic t_latch_pin();
        PO_IN <= 8'h3c;
        sink <= 8'h02;
        apb(1'b1, 8'h80, 32'h5a);
        apb(1'b1, 8'h90, 32'h0f);
        settle();
        rchk(8'h80, 8'h5a);
        rchk(8'h84, 8'h58);
        `CHK("port zero pins", 8'h58, PZ_IN)
        rchk(8'h90, 8'h0f);
        `CHK("analog select", 8'h0f, ANALOG_SEL)
        rchk(8'h94, 8'h3c);
    endtask
    task automatic t_port_two();
        sink <= 8'h00;
        apb(1'b1, 8'ha0, 32'h9e);
        settle();
        `CHK("port two pins", 8'h9e, PT_IN)
        apb(1'b1, 8'hc4, 32'h1f);
        sink <= 8'h90;
        settle();
        `CHK("pulse pins", 2'b01, PT_IN[6:5])
        `CHK("spi pins", 2'b01, PT_IN[1:0])
        `CHK("miso pin", 1'b0, SPI_MISO_IN)
        `CHK("timer c", 3'b101, {TIMER_C_CLOCK_INPUT, TIMER_C_EXT_CONTROL,
            SPI_SLAVE_SEL})
        `CHK("alt clock", 1'b0, PULSE_GEN_ALT_CLOCK)
        sink <= 8'h00;
        settle();
        `CHK("alt clock", 1'b1, PULSE_GEN_ALT_CLOCK)
        apb(1'b1, 8'hc4, 32'h20);
    endtask
    task automatic t_port_three();
        sink <= 8'h24;
        settle();
        `CHK("strobe pins", 2'b10, PH_IN[7:6])
        `CHK("serial and counters", 3'b010, {TIMER_B_COUNT_INPUT,
            TIMER_A_COUNT_INPUT, UART_RX})
        `CHK("irq inputs", 2'b10, {EXT_IRQ_B, EXT_IRQ_A})
        apb(1'b1, 8'hb0, 32'h7d);
        settle();
        `CHK("gated pins", 2'b00, {PH_IN[7], PH_IN[1]})
    endtask
    task automatic t_bit_ops();
        logic [15:0] cmd [4] = '{16'h0220, 16'h0127, 16'h0323, 16'h1026};
        logic [7:0]  exp [4] = '{8'h9f, 8'h1f, 8'h17, 8'h57};
        sink <= 8'h08;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'hc0, {16'h0, cmd[i]});
            rchk(8'ha0, exp[i]);
        end
        sink <= 8'h00;
    endtask
    task automatic t_ext();
        @(posedge MCLK);
        EXT_START <= 1'b1;
        @(posedge MCLK);
        EXT_START <= 1'b0;
        settle();
        rchk(8'h80, 8'hff);
        EXT_ACTIVE <= 1'b1;
        settle();
        `CHK("low bus pins", 8'ha5, PZ_IN)
        `CHK("high address pins", 8'h34, PT_IN)
        EXT_ACTIVE <= 1'b0;
        settle();
        `CHK("port zero pins", 8'hff, PZ_IN)
        apb(1'b0, 8'h08, 32'h0);
        `CHK("unmapped error", 1'b1, serr)
        `CHK("unmapped data", 32'h0, rdat)
    endtask

    // Main sequence: reset for eight cycles, then every scenario.
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, EXT_START, EXT_ACTIVE} = 6'h0;
        {EXT_WR_STROBE, EXT_RD_STROBE, PULSE_OUT_A, PULSE_OUT_B} = 4'h6;
        {SPI_CLOCK_OUT, SPI_MOSI_OUT, UART_TX} = 3'h5;
        {PADDR, PWDATA, sink, PO_IN} = '0;
        EXT_ADDR_LOW_DATA = 8'ha5;
        EXT_ADDR_HIGH = 16'h1234;
        repeat (8) @(posedge MCLK);
        NRST <= 1'b1;
        t_reset();
        t_latch_pin();
        t_port_two();
        t_port_three();
        t_bit_ops();
        t_ext();
        print_verdict();
    end
endmodule
